// File: hw/usb_ep_pkg.sv
// Shared constants and types for the USB endpoint toggle and event block.
// Assumes one AXI4-Lite slave port with 32-bit data and word-indexed registers.
package usb_ep_pkg;
    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int STRB_W = DATA_W / 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] EP_STRIDE = 10'h020;
    localparam logic [IDX_W-1:0] CFG_IDX = 10'h100;
    localparam logic [IDX_W-1:0] STCLR_IDX = 10'h104;
    localparam logic [IDX_W-1:0] STSET_IDX = 10'h105;
    localparam logic [IDX_W-1:0] STATUS_IDX = 10'h106;
    localparam logic [IDX_W-1:0] FLAG_IDX = 10'h107;
    localparam logic [IDX_W-1:0] ENCLR_IDX = 10'h108;
    localparam logic [IDX_W-1:0] ENSET_IDX = 10'h109;

    // ----------------------------------------------------------------
    // Field positions, masks and reset values
    // ----------------------------------------------------------------
    localparam int ST_OUT_TGL = 0;
    localparam int ST_IN_TGL = 1;
    localparam int ST_CURBK = 2;
    localparam int CFG_DBL = 0;
    localparam int EV_DONE0 = 0;
    localparam int EV_DONE1 = 1;
    localparam int EV_FAIL0 = 2;
    localparam int EV_FAIL1 = 3;
    localparam int EV_SETUP = 4;
    localparam int EV_BANK0_STALL_FLAG = 5;
    localparam int EV_BANK1_STALL_FLAG = 6;
    localparam logic [REG_W-1:0] FLAG_MASK = 8'h7F;
    localparam logic [REG_W-1:0] STATUS_MASK = 8'h07;
    localparam logic [REG_W-1:0] CFG_MASK = 8'h01;
    localparam logic [REG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [REG_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [REG_W-1:0] CFG_RESET = 8'h00;

    // One-cycle strobes from the USB packet engine, same clock
    typedef struct packed {
        logic stall;
        logic setup;
        logic fail;
        logic done;
        logic dir_in;
    } usb_event_t;
endpackage

// File: hw/usb_ep_events.sv
// Endpoint data-toggle state, event flags and interrupt enables for one
// USB device endpoint, reached over AXI4-Lite.
// Assumes the packet engine runs on aclk and pulses usb_evt for one cycle.
`timescale 1ns/1ps
`default_nettype none

module usb_ep_events
    import usb_ep_pkg::*;
#(
    parameter int EP_NUM = 0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire usb_event_t usb_evt,
    output logic irq,
    output logic in_toggle_bit,
    output logic out_toggle_bit,
    output logic current_bank
);
    // ----------------------------------------------------------------
    // Register indices of this endpoint
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] EP_OFF = IDX_W'(EP_NUM) * EP_STRIDE;
    localparam logic [IDX_W-1:0] A_CFG = CFG_IDX + EP_OFF;
    localparam logic [IDX_W-1:0] A_STCLR = STCLR_IDX + EP_OFF;
    localparam logic [IDX_W-1:0] A_STSET = STSET_IDX + EP_OFF;
    localparam logic [IDX_W-1:0] A_STATUS = STATUS_IDX + EP_OFF;
    localparam logic [IDX_W-1:0] A_FLAG = FLAG_IDX + EP_OFF;
    localparam logic [IDX_W-1:0] A_ENCLR = ENCLR_IDX + EP_OFF;
    localparam logic [IDX_W-1:0] A_ENSET = ENSET_IDX + EP_OFF;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [REG_W-1:0] flags_reg;
    logic [REG_W-1:0] enable_reg;
    logic [REG_W-1:0] status_reg;
    logic [REG_W-1:0] cfg_reg;
    logic irq_reg;
    logic [IDX_W-1:0] aw_idx_reg;
    logic aw_got_reg;
    logic [REG_W-1:0] wbyte_reg;
    logic wlane_reg;
    logic w_got_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ----------------------------------------------------------------
    // Write channel handshakes
    // ----------------------------------------------------------------
    // Address and data are caught independently; commit needs both
    wire aw_hs = awvalid & awready_reg;
    wire w_hs = wvalid & wready_reg;
    wire wr_go = aw_got_reg & w_got_reg & ~bvalid_reg;
    wire aw_got_next = (aw_got_reg | aw_hs) & ~wr_go;
    wire w_got_next = (w_got_reg | w_hs) & ~wr_go;
    wire bvalid_next = wr_go | (bvalid_reg & ~bready);

    // Write decode; only byte lane 0 carries register bits
    wire wr_ok = wr_go & wlane_reg;
    wire hit_cfg = (aw_idx_reg == A_CFG);
    wire hit_stclr = (aw_idx_reg == A_STCLR);
    wire hit_stset = (aw_idx_reg == A_STSET);
    wire hit_status = (aw_idx_reg == A_STATUS);
    wire hit_flag = (aw_idx_reg == A_FLAG);
    wire hit_enclr = (aw_idx_reg == A_ENCLR);
    wire hit_enset = (aw_idx_reg == A_ENSET);
    wire wr_mapped = hit_cfg | hit_stclr | hit_stset | hit_status
                   | hit_flag | hit_enclr | hit_enset;

    // ----------------------------------------------------------------
    // Software write effects
    // ----------------------------------------------------------------
    // All five are write-one-only strobes; zeros are harmless
    wire [REG_W-1:0] flag_clr = (wr_ok & hit_flag) ? (wbyte_reg & FLAG_MASK)
                                                  : '0;
    wire [REG_W-1:0] en_clr = (wr_ok & hit_enclr) ? (wbyte_reg & FLAG_MASK)
                                                 : '0;
    wire [REG_W-1:0] en_set = (wr_ok & hit_enset) ? (wbyte_reg & FLAG_MASK)
                                                 : '0;
    wire [REG_W-1:0] st_clr = (wr_ok & hit_stclr) ? (wbyte_reg & STATUS_MASK)
                                                 : '0;
    wire [REG_W-1:0] st_set = (wr_ok & hit_stset) ? (wbyte_reg & STATUS_MASK)
                                                 : '0;
    wire cfg_we = wr_ok & hit_cfg;

    // ----------------------------------------------------------------
    // Bank selection and hardware events
    // ----------------------------------------------------------------
    // Single bank: IN uses bank 1, OUT bank 0; double bank follows curbk
    wire dbl = cfg_reg[CFG_DBL];
    wire bank1 = dbl ? status_reg[ST_CURBK] : usb_evt.dir_in;
    logic [REG_W-1:0] ev_set;
    assign ev_set[EV_BANK1_STALL_FLAG] = usb_evt.stall & bank1;
    assign ev_set[EV_BANK0_STALL_FLAG] = usb_evt.stall & ~bank1;
    assign ev_set[EV_SETUP] = usb_evt.setup;
    assign ev_set[EV_FAIL1] = usb_evt.fail & bank1;
    assign ev_set[EV_FAIL0] = usb_evt.fail & ~bank1;
    assign ev_set[EV_DONE1] = usb_evt.done & bank1;
    assign ev_set[EV_DONE0] = usb_evt.done & ~bank1;
    assign ev_set[REG_W-1] = 1'b0;
    // A fail only raises the flag; its cause is kept in descriptor RAM
    // by the packet engine, not here.

    // Toggle flips on every completed data transaction; the bank flips only in double-bank mode
    logic [REG_W-1:0] hw_flip;
    assign hw_flip[ST_IN_TGL] = usb_evt.done & usb_evt.dir_in;
    assign hw_flip[ST_OUT_TGL] = usb_evt.done & ~usb_evt.dir_in;
    assign hw_flip[ST_CURBK] = usb_evt.done & dbl;
    assign hw_flip[REG_W-1:3] = '0;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    // Flags: a new event in the clearing cycle survives the clear
    wire [REG_W-1:0] flags_next = (flags_reg & ~flag_clr) | ev_set;
    // One storage for both enable views; set and clear never coincide
    wire [REG_W-1:0] en_next = (enable_reg | en_set) & ~en_clr;
    // Software writes win over a same-cycle toggle flip
    wire [REG_W-1:0] status_next = ((status_reg ^ hw_flip) & ~st_clr)
                                 | st_set;
    wire irq_next = |(flags_next & en_next);

    // ----------------------------------------------------------------
    // Endpoint state registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= FLAG_RESET;
            enable_reg <= ENABLE_RESET;
            status_reg <= STATUS_RESET;
            cfg_reg <= CFG_RESET;
            irq_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            enable_reg <= en_next;
            status_reg <= status_next;
            cfg_reg <= cfg_we ? (wbyte_reg & CFG_MASK) : cfg_reg;
            irq_reg <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // AXI write path
    // ----------------------------------------------------------------
    // Each channel stalls after one beat until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awready_reg <= ~aw_got_next & ~bvalid_next;
            wready_reg <= ~w_got_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
        end
    end

    // Payload capture, reset to zero and OKAY along with the valid flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx_reg <= '0;
            wbyte_reg <= '0;
            wlane_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_idx_reg <= awaddr[ADDR_W-1:2];
            end
            if (w_hs) begin
                wbyte_reg <= wdata[REG_W-1:0];
                wlane_reg <= wstrb[0];
            end
            if (wr_go) begin
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI read path
    // ----------------------------------------------------------------
    wire ar_hs = arvalid & arready_reg;
    wire [IDX_W-1:0] rd_idx = araddr[ADDR_W-1:2];
    wire rd_cfg = (rd_idx == A_CFG);
    wire rd_st = (rd_idx == A_STCLR) | (rd_idx == A_STSET)
               | (rd_idx == A_STATUS);
    wire rd_flag = (rd_idx == A_FLAG);
    // Both enable views read the one shared enable store
    wire rd_en = (rd_idx == A_ENCLR) | (rd_idx == A_ENSET);
    wire rd_hit = rd_cfg | rd_st | rd_flag | rd_en;
    // Status view holds the toggle bits that select DATA0 or DATA1
    wire [REG_W-1:0] rd_byte = rd_cfg ? cfg_reg
                             : rd_st ? status_reg
                             : rd_flag ? flags_reg
                             : rd_en ? enable_reg
                             : '0;
    wire rvalid_next = ar_hs | (rvalid_reg & ~rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign irq = irq_reg;
    assign in_toggle_bit = status_reg[ST_IN_TGL];
    assign out_toggle_bit = status_reg[ST_OUT_TGL];
    assign current_bank = status_reg[ST_CURBK];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_in_toggle_set: assert property (
        st_set[ST_IN_TGL] |=> in_toggle_bit && $past(hit_stset))
    else $error("IN toggle not set by status-set write");

    chk_out_toggle_set: assert property (
        st_set[ST_OUT_TGL] |=> out_toggle_bit)
    else $error("OUT toggle not set by status-set write");

    chk_toggle_clear: assert property (
        (wr_ok && hit_stclr && wbyte_reg[ST_IN_TGL]) |=> !in_toggle_bit)
    else $error("IN toggle not cleared by status-clear write");

    chk_flag_sticky: assert property (
        ##1 (($past(flags_reg) & ~$past(flag_clr) & ~flags_reg) == '0))
    else $error("Event flag dropped without a clear write");

    chk_stall_bank: assert property (
        (usb_evt.stall && bank1) |=> flags_reg[EV_BANK1_STALL_FLAG])
    else $error("Bank 1 stall flag not raised");

    chk_stall_zero: assert property (
        (usb_evt.stall && !bank1) |=> flags_reg[EV_BANK0_STALL_FLAG]
            && !(flags_reg[EV_BANK1_STALL_FLAG] && !$past(flags_reg[EV_BANK1_STALL_FLAG])))
    else $error("Bank 0 stall flag wrong");

    chk_setup_flag: assert property (
        usb_evt.setup |=> flags_reg[EV_SETUP])
    else $error("Setup flag not raised");

    // A same-cycle software status write wins over the bank flip, so leave it out
    chk_done_bank: assert property (
        (usb_evt.done && dbl && status_reg[ST_CURBK] && st_set == '0 && st_clr == '0)
            |=> flags_reg[EV_DONE1] && !current_bank)
    else $error("Double-bank completion handled wrongly");

    chk_irq_level: assert property (
        irq == |(flags_reg & enable_reg))
    else $error("Interrupt does not match enabled flags");

    chk_enable_clear: assert property (
        (en_clr != '0) |=> ((enable_reg & $past(en_clr)) == '0))
    else $error("Enable-clear write left an enable set");

    chk_toggle_flip: assert property (
        (usb_evt.done && usb_evt.dir_in && st_set == '0 && st_clr == '0)
            |=> in_toggle_bit != $past(in_toggle_bit))
    else $error("IN toggle did not invert after a transaction");

    chk_write_resp: assert property (
        wr_go |=> bvalid && !awready && !wready)
    else $error("Write response missing after commit");

    chk_fail_bank1: assert property (
        (usb_evt.fail && bank1) |=> flags_reg[EV_FAIL1])
    else $error("Bank 1 fail flag not raised");

    chk_fail_bank0: assert property (
        (usb_evt.fail && !bank1) |=> flags_reg[EV_FAIL0])
    else $error("Bank 0 fail flag not raised");

    chk_done_zero: assert property (
        (usb_evt.done && !bank1) |=> flags_reg[EV_DONE0])
    else $error("Bank 0 completion flag not raised");

    chk_enable_set: assert property (
        (en_set != '0) |=> ((enable_reg & $past(en_set)) == $past(en_set)))
    else $error("Enable-set write left an enable clear");

    chk_out_clear: assert property (
        (wr_ok && hit_stclr && wbyte_reg[ST_OUT_TGL]) |=> !out_toggle_bit)
    else $error("OUT toggle not cleared by status-clear write");

    chk_out_flip: assert property (
        (usb_evt.done && !usb_evt.dir_in && st_set == '0 && st_clr == '0)
            |=> out_toggle_bit != $past(out_toggle_bit))
    else $error("OUT toggle did not invert after a transaction");

    chk_flag_spare: assert property (
        !flags_reg[REG_W-1])
    else $error("Unused flag bit became set");

    // The bus master may stall; the answer must not move under it
    chk_read_resp: assert property (
        ar_hs |=> rvalid && !arready)
    else $error("Read answer missing after address taken");

    chk_read_hold: assert property (
        (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("Read answer changed while not accepted");

    chk_resp_hold: assert property (
        (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("Write response changed while not accepted");
endmodule

`default_nettype wire

// File: verification/usb_ep_host_model.sv
// Stand-in for the packet engine that reacts to the USB host on the bus.
// Assumes the same aclk as the endpoint block and one-cycle event strobes.
`timescale 1ns/1ps
`default_nettype none

module usb_ep_host_model
    import usb_ep_pkg::*;
(
    input wire logic aclk,
    output usb_event_t usb_evt
);
    // ----------------------------------------------------------------
    // Event strobe generation
    // ----------------------------------------------------------------
    // Idle between packets so a stale strobe never double-counts
    initial begin
        usb_evt = '0;
    end

    // One packet outcome: strobe high for exactly one edge, dir_in with it
    task automatic send(input usb_event_t e);
        @(posedge aclk);
        usb_evt <= e;
        @(posedge aclk);
        usb_evt <= '0;
    endtask
endmodule
`default_nettype wire

// File: verification/usb_endpoint_toggle_and_interrupts_tb_top.sv
// Self-checking bench for the endpoint toggle and event block.
// Assumes one AXI4-Lite master here and the packet engine model beside it.
`timescale 1ns/1ps
`default_nettype none

module usb_endpoint_toggle_and_interrupts_tb_top
    import usb_ep_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals, clock and design
    // ----------------------------------------------------------------
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, in_toggle_bit, out_toggle_bit, current_bank;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp;
    usb_event_t usb_evt;
    int err_total, total_checks;
    logic [4:0] ev;
    int b;

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    usb_ep_events #(.EP_NUM(0)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .usb_evt(usb_evt), .irq(irq), .in_toggle_bit(in_toggle_bit),
        .out_toggle_bit(out_toggle_bit), .current_bank(current_bank));

    usb_ep_host_model host_u (.aclk(aclk), .usb_evt(usb_evt));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                      input logic [3:0] st, input logic [1:0] er);
        logic fin;
        fin = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                fin = 1'b1;
                chk({30'h0, bresp}, {30'h0, er});
            end
        end
    endtask

    // Read one word and compare data and response
    task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] e, input logic [1:0] er);
        logic fin;
        fin = 1'b0;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                fin = 1'b1;
                chk(rdata, {24'h000000, e});
                chk({30'h0, rresp}, {30'h0, er});
            end
        end
    endtask

    // Let registered outputs land before looking at them
    task automatic settle;
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // Order: in toggle, out toggle, current bank, interrupt
    task automatic pins(input logic [3:0] e);
        chk({28'h0, in_toggle_bit, out_toggle_bit, current_bank, irq}, {28'h0, e});
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        err_total = 0;
        total_checks = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        pins(4'b0000);
        rdc(FLAG_IDX, 8'h00, RESP_OKAY);
        rdc(ENCLR_IDX, 8'h00, RESP_OKAY);
        rdc(STATUS_IDX, 8'h00, RESP_OKAY);
        wr(STSET_IDX, 8'h02, 4'hF, RESP_OKAY);
        settle;
        pins(4'b1000);
        wr(STSET_IDX, 8'h01, 4'hF, RESP_OKAY);
        settle;
        pins(4'b1100);
        rdc(STATUS_IDX, 8'h03, RESP_OKAY);
        // Status is read-only, zero clears nothing, a strobe-less write is dropped
        wr(STATUS_IDX, 8'h00, 4'hF, RESP_OKAY);
        wr(STCLR_IDX, 8'h00, 4'hF, RESP_OKAY);
        wr(STCLR_IDX, 8'h03, 4'h0, RESP_OKAY);
        settle;
        pins(4'b1100);
        wr(STCLR_IDX, 8'h02, 4'hF, RESP_OKAY);
        settle;
        pins(4'b0100);
        host_u.send(usb_event_t'(5'b00011));
        settle;
        pins(4'b1100);
        host_u.send(usb_event_t'(5'b00010));
        settle;
        pins(4'b1000);
        rdc(FLAG_IDX, 8'h03, RESP_OKAY);
        wr(FLAG_IDX, 8'h00, 4'hF, RESP_OKAY);
        rdc(FLAG_IDX, 8'h03, RESP_OKAY);
        wr(FLAG_IDX, 8'h01, 4'hF, RESP_OKAY);
        rdc(FLAG_IDX, 8'h02, RESP_OKAY);
        settle;
        pins(4'b1000);
        wr(ENSET_IDX, 8'h02, 4'hF, RESP_OKAY);
        settle;
        pins(4'b1001);
        rdc(ENCLR_IDX, 8'h02, RESP_OKAY);
        wr(ENCLR_IDX, 8'h00, 4'hF, RESP_OKAY);
        settle;
        pins(4'b1001);
        wr(ENCLR_IDX, 8'h02, 4'hF, RESP_OKAY);
        settle;
        pins(4'b1000);
        rdc(ENSET_IDX, 8'h00, RESP_OKAY);
        wr(ENSET_IDX, 8'h7F, 4'hF, RESP_OKAY);
        wr(FLAG_IDX, 8'h7F, 4'hF, RESP_OKAY);
        settle;
        chk({31'h0, irq}, 32'h0);
        // Every event kind in both directions, single bank
        for (int k = 0; k < 4; k++) begin
            for (int d = 0; d < 2; d++) begin
                ev = 5'b00000;
                ev[4-k] = 1'b1;
                ev[0] = d[0];
                b = (k == 0) ? (d ? 6 : 5) : (k == 1) ? 4 : (k == 2) ? (d ? 3 : 2) : d;
                host_u.send(usb_event_t'(ev));
                settle;
                chk({31'h0, irq}, 32'h1);
                rdc(FLAG_IDX, 8'h01 << b, RESP_OKAY);
                wr(FLAG_IDX, 8'h7F, 4'hF, RESP_OKAY);
            end
        end
        // Double bank: the current bank, not the direction, picks the flag
        wr(CFG_IDX, 8'h01, 4'hF, RESP_OKAY);
        wr(STSET_IDX, 8'h04, 4'hF, RESP_OKAY);
        host_u.send(usb_event_t'(5'b10000));
        settle;
        rdc(FLAG_IDX, 8'h40, RESP_OKAY);
        wr(FLAG_IDX, 8'h7F, 4'hF, RESP_OKAY);
        wr(STCLR_IDX, 8'h04, 4'hF, RESP_OKAY);
        host_u.send(usb_event_t'(5'b00101));
        settle;
        rdc(FLAG_IDX, 8'h04, RESP_OKAY);
        host_u.send(usb_event_t'(5'b00011));
        settle;
        rdc(FLAG_IDX, 8'h05, RESP_OKAY);
        chk({31'h0, current_bank}, 32'h1);
        // Bank one is now current: an OUT completion must land on bank one
        host_u.send(usb_event_t'(5'b00010));
        settle;
        rdc(FLAG_IDX, 8'h07, RESP_OKAY);
        chk({31'h0, current_bank}, 32'h0);
        // Unmapped place
        wr(10'h000, 8'hFF, 4'hF, RESP_SLVERR);
        rdc(10'h000, 8'h00, RESP_SLVERR);
        summarize;
    end

    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        repeat (50000) @(posedge aclk);
        err_total++;
        summarize;
    end
endmodule
`default_nettype wire
